// >>> dv/test_xyca_acq.sv
// testbench for the x/y curve acquisition block
`timescale 1ns/1ns
module test_xyca_acq;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic meas_start = 1'b0;
    logic meas_stop = 1'b0;
    logic [31:0] cfg_edit_val = 32'h0;
    logic [2:0] cfg_edit_sel = 3'h0;
    logic cfg_edit_wr = 1'b0;
    logic cfg_confirm = 1'b0;
    logic cfg_discard = 1'b0;
    logic y_is_piezo = 1'b0;
    logic pair_ready = 1'b0;
    logic signed [31:0] x_in, y_in, pair_x, pair_y, x_offset;
    logic sample_valid, piezo_short, amp_enable, running, mem_full, offset_valid, pair_valid;
    logic [12:0] pair_count;
    int num_errors = 0;
    int checks = 0;
    int gap = 2010;
    int xs[4] = '{10, 20, 30, 40};
    int ys[4] = '{0, 200, 0, 0};
    int first[6] = '{0, 0, 0, 0, 1, 2};
    int offs[6] = '{0, 40, 20, 30, 0, 0};

    // small depth keeps the full-memory case inside the run
    xyca_acq #(.DEPTH(4)) u_xyca_acq (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .meas_start(meas_start), .meas_stop(meas_stop),
        .x_in(x_in), .y_in(y_in), .sample_valid(sample_valid), .cfg_edit_val(cfg_edit_val),
        .cfg_edit_sel(cfg_edit_sel), .cfg_edit_wr(cfg_edit_wr), .cfg_confirm(cfg_confirm),
        .cfg_discard(cfg_discard), .y_is_piezo(y_is_piezo), .piezo_short(piezo_short),
        .amp_enable(amp_enable), .running(running), .mem_full(mem_full),
        .pair_count(pair_count), .x_offset(x_offset), .offset_valid(offset_valid),
        .pair_x(pair_x), .pair_y(pair_y), .pair_valid(pair_valid), .pair_ready(pair_ready)
    );
    xyca_sensor_model u_xyca_sensor_model (
        .sys_clk(sys_clk), .x_in(x_in), .y_in(y_in), .sample_valid(sample_valid)
    );

    initial begin
        forever #25 sys_clk = ~sys_clk;
    end

    task automatic wrap_up;
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : tick

    task automatic cfg(input logic [2:0] sel, input logic [31:0] val, input bit ok);
        @(negedge sys_clk);
        cfg_edit_sel = sel;
        cfg_edit_val = val;
        cfg_edit_wr = 1'b1;
        @(negedge sys_clk);
        cfg_edit_wr = 1'b0;
        cfg_confirm = ok;
        cfg_discard = !ok;
        @(negedge sys_clk);
        cfg_confirm = 1'b0;
        cfg_discard = 1'b0;
    endtask : cfg

    task automatic meas(input bit go);
        @(negedge sys_clk);
        meas_start = go;
        meas_stop = !go;
        @(negedge sys_clk);
        meas_start = 1'b0;
        meas_stop = 1'b0;
        tick(1);
        chk(running, go);
        chk(piezo_short, !go);
        chk(amp_enable, go);
    endtask : meas

    task automatic pop(input logic [31:0] ex, input logic [31:0] ey);
        chk(pair_valid, 1'b1);
        chk(pair_x, ex);
        chk(pair_y, ey);
        pair_ready = 1'b1;
        tick(1);
        pair_ready = 1'b0;
        tick(1);
    endtask : pop

    // st: 0 refused, 1 stored and popped, 2 left in the buffer unchecked
    task automatic smp(input logic signed [31:0] x, input logic signed [31:0] y, input int st,
                       input logic [31:0] ex, input logic [31:0] ey);
        u_xyca_sensor_model.send(x, y);
        tick(2);
        if (st < 2) begin
            chk(pair_valid, st[0]);
        end
        if (st == 1) begin
            pop(ex, ey);
        end
        tick(gap);
    endtask : smp

    initial begin
        repeat (100000) @(posedge sys_clk);
        num_errors++;
        wrap_up();
    end

    initial begin
        tick(3);
        sys_rst = 1'b0;
        tick(1);
        chk(piezo_short, 1'b1);
        chk(amp_enable, 1'b0);
        chk(pair_count, 13'h0);
        cfg(3'h0, 32'h0000000a, 1'b1);
        cfg(3'h5, 32'h00000064, 1'b1);
        cfg(3'h3, 32'h00000001, 1'b1);
        cfg(3'h3, 32'h00000000, 1'b0);
        for (int m = 0; m < 6; m++) begin
            cfg(3'h4, m, 1'b1);
            meas(1'b1);
            for (int i = 0; i < 4; i++) begin
                smp(xs[i], ys[i], i >= first[m], xs[i] - (m >= 4 ? xs[first[m]] : 0),
                    ys[i]);
            end
            meas(1'b0);
            chk(pair_count, 4 - first[m]);
            if (m inside {1, 2, 3}) begin
                chk(offset_valid, 1'b1);
                chk(x_offset, offs[m]);
            end
        end
        y_is_piezo = 1'b1;
        cfg(3'h4, 32'h00000000, 1'b1);
        cfg(3'h1, 32'h00000000, 1'b1);
        cfg(3'h3, 32'h00000002, 1'b1);
        u_xyca_sensor_model.send(5, 500);
        meas(1'b1);
        smp(5, 500, 1, 5, 0);
        smp(5, 501, 1, 5, 1);
        smp(5, 501, 0, 0, 0);
        meas(1'b0);
        y_is_piezo = 1'b0;
        cfg(3'h2, 32'h000009c4, 1'b1);
        cfg(3'h3, 32'h00000004, 1'b1);
        gap = 2200;
        meas(1'b1);
        smp(7, 9, 1, 7, 9);
        smp(7, 9, 0, 0, 0);
        gap = 2600;
        for (int i = 1; i < 4; i++) begin
            smp(i, 9, 2, 0, 0);
        end
        // third pair was refused while both buffer entries were held
        chk(pair_count, 13'h3);
        pop(1, 9);
        pop(2, 9);
        chk(pair_valid, 1'b0);
        smp(4, 9, 1, 4, 9);
        chk(mem_full, 1'b1);
        smp(5, 9, 0, 0, 0);
        chk(pair_count, 13'h4);
        meas(1'b0);
        wrap_up();
    end
endmodule : test_xyca_acq

// >>> dv/xyca_sensor_model.sv
// sensor front-end model: one x/y pair per one-cycle valid
`timescale 1ns/1ns
module xyca_sensor_model (
    input wire logic sys_clk,
    output logic signed [31:0] x_in,
    output logic signed [31:0] y_in,
    output logic sample_valid
);
    initial begin
        x_in = 32'h0;
        y_in = 32'h0;
        sample_valid = 1'b0;
    end
    // lines carry the inverted value outside valid so a late sample is never mistaken for data
    task automatic send(input logic signed [31:0] x, input logic signed [31:0] y);
        @(negedge sys_clk);
        x_in = x;
        y_in = y;
        sample_valid = 1'b1;
        @(negedge sys_clk);
        sample_valid = 1'b0;
        x_in = ~x;
        y_in = ~y;
    endtask : send
endmodule : xyca_sensor_model

// >>> hdl/xyca_acq.sv
// x/y curve acquisition: sampling criteria, reference modes, piezo gating
`timescale 1ns/1ns
`include "xyca_map.svh"
module xyca_acq #(
    parameter int DW = 32,
    parameter int DEPTH = `XYCA_CURVE_DEPTH,
    parameter int AW = 13
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic meas_start,
    input wire logic meas_stop,
    input wire logic signed [DW-1:0] x_in,
    input wire logic signed [DW-1:0] y_in,
    input wire logic sample_valid,
    input wire logic [DW-1:0] cfg_edit_val,
    input wire logic [2:0] cfg_edit_sel,
    input wire logic cfg_edit_wr,
    input wire logic cfg_confirm,
    input wire logic cfg_discard,
    input wire logic y_is_piezo,
    output logic piezo_short,
    output logic amp_enable,
    output logic running,
    output logic mem_full,
    output logic [AW-1:0] pair_count,
    output logic signed [DW-1:0] x_offset,
    output logic offset_valid,
    output logic signed [DW-1:0] pair_x,
    output logic signed [DW-1:0] pair_y,
    output logic pair_valid,
    input wire logic pair_ready
);
    // cfg word layout: sel 0 x interval, 1 y interval, 2 t interval (ticks),
    // 3 enables {t,y,x}, 4 mode, 5 y level
    localparam int NCFG = 6;
    logic [DW-1:0] cfg [NCFG];
    genvar gi;
    generate
        for (gi = 0; gi < NCFG; gi++) begin : g_cfg
            xyca_cfg_shadow #(.W(DW)) u_sh (
                .sys_clk(sys_clk),
                .sys_rst(sys_rst),
                .edit_val(cfg_edit_val),
                .edit_wr(cfg_edit_wr && (cfg_edit_sel == 3'(gi))),
                .confirm(cfg_confirm),
                .discard(cfg_discard),
                .active_val(cfg[gi])
            );
        end
    endgenerate

    function automatic logic [DW-1:0] abs_diff(input logic signed [DW-1:0] a,
                                               input logic signed [DW-1:0] b);
        abs_diff = (a > b) ? DW'(a - b) : DW'(b - a);
    endfunction : abs_diff

    function automatic logic [DW-1:0] eff_step(input logic [DW-1:0] v);
        eff_step = (v < `XYCA_MIN_DELTA) ? `XYCA_MIN_DELTA : v;
    endfunction : eff_step

    function automatic logic crossed(input logic up, input logic signed [DW-1:0] prev,
                                     input logic signed [DW-1:0] cur,
                                     input logic signed [DW-1:0] lvl);
        crossed = up ? (prev < lvl && cur >= lvl) : (prev > lvl && cur <= lvl);
    endfunction : crossed

    logic [2:0] mode;
    logic en_x, en_y, en_t;
    logic signed [DW-1:0] ylvl;
    assign mode = cfg[4][2:0];
    assign en_x = cfg[3][0];
    assign en_y = cfg[3][1];
    assign en_t = cfg[3][2];
    assign ylvl = cfg[5];

    xyca_pkg::xyca_state_e st_q, st_d;
    logic signed [DW-1:0] lx_q, lx_d, ly_q, ly_d, py_q, py_d, y0_q, y0_d;
    logic signed [DW-1:0] org_q, org_d, off_q, off_d, fx_q, fx_d;
    logic [DW-1:0] tcnt_q, tcnt_d, gap_q, gap_d;
    logic [AW-1:0] cnt_q, cnt_d;
    logic first_q, first_d, hit_q, hit_d, offv_q, offv_d, run_q, run_d;
    // last valid y: the sensor lines carry no meaning between samples
    logic signed [DW-1:0] yh_q, yh_d;
    // output flags registered so no port hangs off logic
    logic short_q, short_d, full_q, full_d;
    logic signed [DW-1:0] yrel, xout;
    logic trig_mode, line_mode, hit, want, store, buf_ready;

    always_comb begin
        trig_mode = (mode == `XYCA_MODE_TRG_UP) || (mode == `XYCA_MODE_TRG_DN);
        line_mode = (mode == `XYCA_MODE_REF_UP) || (mode == `XYCA_MODE_REF_DN);
        // piezo reads change since start
        yrel = y_is_piezo ? DW'(y_in - y0_q) : y_in;
        hit = crossed(mode[0] == 1'b0, py_q, yrel, ylvl);
        want = first_q
            || (en_t && (tcnt_q >= eff_step(cfg[2]) - 1))
            || (en_x && abs_diff(x_in, lx_q) >= eff_step(cfg[0]))
            || (en_y && abs_diff(yrel, ly_q) >= eff_step(cfg[1]));
        // the crossing sample itself is the first stored point of a trigger curve
        store = ((st_q == xyca_pkg::XYCA_RECORD) || ((st_q == xyca_pkg::XYCA_ARMED) && hit))
            && sample_valid && want
            && (gap_q >= DW'(`XYCA_MIN_TICKS))
            && (cnt_q < AW'(DEPTH)) && buf_ready;
        // trigger modes: crossing point sits at x zero
        xout = trig_mode ? ((st_q == xyca_pkg::XYCA_ARMED) ? '0 : DW'(x_in - org_q))
                         : x_in;
        yh_d = sample_valid ? y_in : yh_q;
        st_d = st_q;
        lx_d = lx_q;
        ly_d = ly_q;
        py_d = py_q;
        y0_d = y0_q;
        org_d = org_q;
        off_d = off_q;
        fx_d = fx_q;
        tcnt_d = (tcnt_q == '1) ? tcnt_q : tcnt_q + 1'b1;
        gap_d = (gap_q == '1) ? gap_q : gap_q + 1'b1;
        cnt_d = cnt_q;
        first_d = first_q;
        hit_d = hit_q;
        offv_d = offv_q;
        run_d = run_q;
        if (sample_valid && st_q != xyca_pkg::XYCA_IDLE) begin
            py_d = yrel;
        end
        case (st_q)
            xyca_pkg::XYCA_IDLE, xyca_pkg::XYCA_DONE: begin
                if (meas_start) begin
                    y0_d = sample_valid ? y_in : yh_q;
                    py_d = '0;
                    cnt_d = '0;
                    first_d = 1'b1;
                    hit_d = 1'b0;
                    offv_d = 1'b0;
                    off_d = '0;
                    gap_d = DW'(`XYCA_MIN_TICKS);
                    run_d = 1'b1;
                    // trigger modes hold off recording
                    st_d = trig_mode ? xyca_pkg::XYCA_ARMED
                                     : xyca_pkg::XYCA_RECORD;
                end
            end
            xyca_pkg::XYCA_ARMED: begin
                if (sample_valid && hit) begin
                    org_d = x_in;
                    st_d = xyca_pkg::XYCA_RECORD;
                end
            end
            xyca_pkg::XYCA_RECORD: begin
                if (sample_valid && line_mode && !hit_q && hit) begin
                    hit_d = 1'b1;
                    off_d = x_in;
                end
                if (sample_valid) begin
                    fx_d = x_in;
                end
            end
            default: st_d = xyca_pkg::XYCA_IDLE;
        endcase
        // shared by record and by the trigger crossing in armed
        if (store) begin
            lx_d = x_in;
            ly_d = yrel;
            tcnt_d = '0;
            gap_d = '0;
            first_d = 1'b0;
            cnt_d = cnt_q + 1'b1;
        end
        if (meas_stop && st_q != xyca_pkg::XYCA_IDLE && st_q != xyca_pkg::XYCA_DONE) begin
            st_d = xyca_pkg::XYCA_DONE;
            run_d = 1'b0;
            offv_d = 1'b1;
            if (mode == `XYCA_MODE_FINAL) begin
                off_d = fx_q;
            end else if (trig_mode) begin
                off_d = '0;
            end else if (!line_mode) begin
                off_d = '0;
            end
        end
        short_d = !run_d;
        full_d = (cnt_d == AW'(DEPTH));
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            st_q <= xyca_pkg::XYCA_IDLE;
            lx_q <= '0;
            ly_q <= '0;
            py_q <= '0;
            y0_q <= '0;
            org_q <= '0;
            off_q <= '0;
            fx_q <= '0;
            tcnt_q <= '0;
            gap_q <= '0;
            cnt_q <= '0;
            first_q <= 1'b0;
            hit_q <= 1'b0;
            offv_q <= 1'b0;
            run_q <= 1'b0;
            yh_q <= '0;
            short_q <= 1'b1;
            full_q <= 1'b0;
        end else begin
            yh_q <= yh_d;
            short_q <= short_d;
            full_q <= full_d;
            st_q <= st_d;
            lx_q <= lx_d;
            ly_q <= ly_d;
            py_q <= py_d;
            y0_q <= y0_d;
            org_q <= org_d;
            off_q <= off_d;
            fx_q <= fx_d;
            tcnt_q <= tcnt_d;
            gap_q <= gap_d;
            cnt_q <= cnt_d;
            first_q <= first_d;
            hit_q <= hit_d;
            offv_q <= offv_d;
            run_q <= run_d;
        end
    end

    logic [2*DW-1:0] buf_out;
    logic buf_valid;
    xyca_skid #(.W(2*DW)) u_buf (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .in_data({xout, yrel}),
        .in_valid(store),
        .in_ready(buf_ready),
        .out_data(buf_out),
        .out_valid(buf_valid),
        .out_ready(pair_ready)
    );

    // outputs come from flops: skid storage and state registers
    assign pair_x = buf_out[2*DW-1:DW];
    assign pair_y = buf_out[DW-1:0];
    assign pair_valid = buf_valid;
    assign running = run_q;
    assign amp_enable = run_q;
    assign piezo_short = short_q;
    assign mem_full = full_q;
    assign pair_count = cnt_q;
    assign x_offset = off_q;
    assign offset_valid = offv_q;

    full_stops_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (cnt_q == AW'(DEPTH)) |-> !store)
        else $error("pair stored with full curve memory");
    min_gap_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        store |=> !store [*2])
        else $error("stored pairs closer than minimum spacing");
    armed_silent_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (st_q == xyca_pkg::XYCA_ARMED && !(sample_valid && hit)) |-> !store)
        else $error("pair stored before trigger crossing");
    piezo_gate_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        piezo_short == (st_q == xyca_pkg::XYCA_IDLE || st_q == xyca_pkg::XYCA_DONE))
        else $error("piezo short not tied to measurement phase");
    start_run_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (meas_start && !run_q) |=> amp_enable && !piezo_short)
        else $error("amplifier not enabled on start");
    timer_restart_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        store |=> tcnt_q == '0)
        else $error("time counter not restarted after store");
    count_step_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        store |=> cnt_q == $past(cnt_q) + 1'b1)
        else $error("pair count did not advance on store");
    final_off_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (meas_stop && run_q && mode == `XYCA_MODE_FINAL) |=> off_q == $past(fx_q))
        else $error("final force offset wrong");
    full_flag_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        mem_full == (cnt_q == AW'(DEPTH)))
        else $error("full flag disagrees with pair count");
    start_ref_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (meas_start && !run_q && sample_valid) |=> y0_q == $past(y_in))
        else $error("piezo start value not captured");
    abs_x_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (store && mode == `XYCA_MODE_ABS) |-> xout == x_in)
        else $error("absolute mode shifted x");
    trig_zero_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (store && st_q == xyca_pkg::XYCA_ARMED) |-> xout == '0)
        else $error("trigger crossing not at x zero");
endmodule : xyca_acq

// >>> hdl/xyca_cfg_shadow.sv
// settings shadow: edits take effect only on confirm
`timescale 1ns/1ns
`include "xyca_map.svh"
module xyca_cfg_shadow #(
    parameter int W = 32
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [W-1:0] edit_val,
    input wire logic edit_wr,
    input wire logic confirm,
    input wire logic discard,
    output logic [W-1:0] active_val
);
    logic [W-1:0] pend_q, pend_d, act_q, act_d;
    always_comb begin
        pend_d = pend_q;
        act_d = act_q;
        if (discard) begin
            pend_d = act_q;
        end else if (edit_wr) begin
            pend_d = edit_val;
        end
        if (confirm) begin
            act_d = pend_q;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pend_q <= '0;
            act_q <= '0;
        end else begin
            pend_q <= pend_d;
            act_q <= act_d;
        end
    end
    assign active_val = act_q;
endmodule : xyca_cfg_shadow

// >>> hdl/xyca_map.svh
// constants for the x/y curve acquisition block
`ifndef XYCA_MAP_SVH
`define XYCA_MAP_SVH
`define XYCA_CURVE_DEPTH 5000
`define XYCA_MIN_PERIOD_NS 100000
`define XYCA_CLK_PERIOD_NS 50
`define XYCA_MIN_TICKS ((`XYCA_MIN_PERIOD_NS + `XYCA_CLK_PERIOD_NS - 1) / `XYCA_CLK_PERIOD_NS)
`define XYCA_MIN_DELTA 32'h0000_0001
`define XYCA_MODE_ABS 3'h0
`define XYCA_MODE_FINAL 3'h1
`define XYCA_MODE_REF_UP 3'h2
`define XYCA_MODE_REF_DN 3'h3
`define XYCA_MODE_TRG_UP 3'h4
`define XYCA_MODE_TRG_DN 3'h5
`endif

// >>> hdl/xyca_pkg.sv
// types for the x/y curve acquisition block
package xyca_pkg;
    typedef enum logic [1:0] {
        XYCA_IDLE,
        XYCA_ARMED,
        XYCA_RECORD,
        XYCA_DONE
    } xyca_state_e;
endpackage : xyca_pkg

// >>> hdl/xyca_skid.sv
// two-entry buffer for stored value pairs
`timescale 1ns/1ns
module xyca_skid #(
    parameter int W = 64
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [W-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [W-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    logic [W-1:0] mem_q [2];
    logic [W-1:0] mem_d [2];
    logic [1:0] cnt_q, cnt_d;
    logic rd_q, rd_d, wr_q, wr_d;
    logic push, pop;
    always_comb begin
        push = in_valid && (cnt_q != 2'h2);
        pop = out_ready && (cnt_q != 2'h0);
        mem_d = mem_q;
        if (push) begin
            mem_d[wr_q] = in_data;
        end
        wr_d = push ? ~wr_q : wr_q;
        rd_d = pop ? ~rd_q : rd_q;
        cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
    end
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cnt_q <= 2'h0;
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            mem_q[0] <= '0;
            mem_q[1] <= '0;
        end else begin
            cnt_q <= cnt_d;
            rd_q <= rd_d;
            wr_q <= wr_d;
            mem_q <= mem_d;
        end
    end
    assign in_ready = (cnt_q != 2'h2);
    assign out_valid = (cnt_q != 2'h0);
    assign out_data = mem_q[rd_q];
endmodule : xyca_skid
